// file: verilog/mad_pkg.sv
/*
  Shared constants, opcode set and state record of the
  multiplier and ALU datapath.
  Assumes one clock domain and a decoder issuing one opcode at a time.
*/
package mad_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] ADR_STATUS  = 4'h0;
  localparam logic [3:0] ADR_ACCUM   = 4'h4;
  localparam logic [3:0] ADR_PRODUCT = 4'h8;
  localparam logic [3:0] ADR_MCAND   = 4'hC;

  // ----------------------------------------
  // Status word fields
  // ----------------------------------------
  localparam int ST_PSEL_LO = 0;
  localparam int ST_PSEL_HI = 1;
  localparam int ST_SEXT    = 2;
  localparam int ST_SAT     = 3;
  localparam int ST_CARRY   = 4;
  localparam int ST_OVF     = 5;
  localparam int ST_TEST    = 6;

  // ----------------------------------------
  // Reset values and fixed numbers
  // ----------------------------------------
  localparam logic [1:0]  PSEL_NONE  = 2'h0;
  localparam logic [1:0]  PSEL_L1    = 2'h1;
  localparam logic [1:0]  PSEL_L4    = 2'h2;
  localparam logic [1:0]  PSEL_R6    = 2'h3;
  localparam logic        SEXT_RST   = 1'b1;
  localparam logic        SAT_RST    = 1'b0;
  localparam logic        CARRY_RST  = 1'b1;
  localparam logic [31:0] SAT_POS    = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG    = 32'h8000_0000;
  localparam logic [4:0]  SHIFT_HIGH = 5'h10;

  // ----------------------------------------
  // Operations
  // ----------------------------------------
  typedef enum logic [5:0] {
    OP_NOP, OP_LOAD_MULT, OP_LOAD_MULT_PROD, OP_LOAD_MULT_ADD,
    OP_LOAD_MULT_ADD_MOVE, OP_LOAD_MULT_SUB, OP_MUL_SIGNED,
    OP_MUL_UNSIGNED, OP_MUL_IMM, OP_SQUARE_ADD, OP_SQUARE_SUB,
    OP_MULT_ACCUM, OP_MULT_ACCUM_MOVE, OP_LOAD, OP_LOAD_VAR, OP_ADD,
    OP_ADD_VAR, OP_ADD_CARRY, OP_SUB, OP_SUB_VAR, OP_SUB_BORROW,
    OP_AND, OP_OR, OP_XOR, OP_BIT_TEST_VAR, OP_STORE_PROD_HIGH,
    OP_STORE_PROD_LOW, OP_LOAD_PROD_HIGH, OP_SHIFT_LEFT,
    OP_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
    OP_BRANCH_OVF, OP_BRANCH_ZERO, OP_JUMP_ACCUM
  } mad_op_t;

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]  productShiftSel;
    logic        signExtEnable;
    logic        saturateEnable;
    logic        carryFlag;
    logic        overflowFlag;
    logic        testFlag;
    logic [15:0] multiplicand;
    logic [31:0] product;
    logic [31:0] accum;
    logic [15:0] coefAddr;
    logic        immPending;
    logic        ack;
    logic [31:0] rdData;
    logic        storeWr;
    logic [15:0] storeData;
    logic        moveWr;
    logic [15:0] moveData;
    logic        branchTake;
    logic [15:0] branchAddr;
  } mad_state_t;

endpackage

// file: verilog/mad_datapath.sv
/*
  Multiplier, product shifter, input shifter and central ALU with
  accumulator, flags and a Wishbone classic register slave.
  Assumes opcodes and operand buses come from logic on mclk.
*/
`timescale 1ns/1ps
module mad_datapath
  import mad_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Operation issue
  input  wire logic        opValid,
  output      logic        opReady,
  input  wire mad_op_t     op,
  input  wire logic [4:0]  shiftCnt,
  input  wire logic [12:0] immVal,
  // Operand buses
  input  wire logic [15:0] dataReadBus,
  input  wire logic [15:0] programReadBus,
  // Coefficient address generation
  input  wire logic        coefLoad,
  input  wire logic [15:0] coefStart,
  output      logic [15:0] coefAddr,
  // Results
  output      logic [31:0] accum,
  output      logic        carryFlag,
  output      logic        overflowFlag,
  output      logic        testFlag,
  output      logic        storeWr,
  output      logic [15:0] storeData,
  output      logic        moveWr,
  output      logic [15:0] moveData,
  output      logic        branchTake,
  output      logic [15:0] branchAddr,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output      logic [31:0] dat_o,
  output      logic        ack_o
);

  mad_state_t         s_q;
  mad_state_t         s_d;
  logic               acceptOp;
  logic               wbHit;
  logic [31:0]        prodShifted;
  logic [31:0]        dataExt;
  logic [31:0]        scaled;
  logic [4:0]         shAmt;
  logic               varOp;
  logic               logicOp;
  logic               useProd;
  logic               subOp;
  logic               cin;
  logic [31:0]        bOperand;
  logic [31:0]        bInv;
  logic [32:0]        sum33;
  logic               aluOv;
  logic [31:0]        arithRes;
  logic [15:0]        mulA;
  logic [15:0]        mulB;
  logic signed [31:0] mulS;
  logic [31:0]        mulU;
  logic [31:0]        statusWord;

  // ----------------------------------------
  // Product shifter
  // ----------------------------------------
  always_comb begin
    unique case (s_q.productShiftSel)
      PSEL_NONE: prodShifted = s_q.product;
      PSEL_L1:   prodShifted = {s_q.product[30:0], 1'b0};
      PSEL_L4:   prodShifted = {s_q.product[27:0], 4'h0};
      PSEL_R6:   prodShifted = {{6{s_q.product[31]}}, s_q.product[31:6]};
    endcase
  end

  // ----------------------------------------
  // Input shifter
  // ----------------------------------------
  assign varOp   = (op == OP_LOAD_VAR) || (op == OP_ADD_VAR) || (op == OP_SUB_VAR);
  assign logicOp = (op == OP_AND) || (op == OP_OR) || (op == OP_XOR);
  assign shAmt   = varOp ? {1'b0, s_q.multiplicand[3:0]} : shiftCnt;
  assign dataExt = (s_q.signExtEnable && !logicOp) ?
                   {{16{dataReadBus[15]}}, dataReadBus} : {16'h0000, dataReadBus};
  assign scaled  = dataExt << shAmt;

  // ----------------------------------------
  // Central ALU adder
  // ----------------------------------------
  assign useProd = (op == OP_LOAD_MULT_ADD) || (op == OP_LOAD_MULT_ADD_MOVE) ||
                   (op == OP_LOAD_MULT_SUB) || (op == OP_SQUARE_ADD) ||
                   (op == OP_SQUARE_SUB) || (op == OP_MULT_ACCUM) ||
                   (op == OP_MULT_ACCUM_MOVE);
  assign subOp   = (op == OP_SUB) || (op == OP_SUB_VAR) || (op == OP_SUB_BORROW) ||
                   (op == OP_LOAD_MULT_SUB) || (op == OP_SQUARE_SUB);
  assign cin     = (op == OP_ADD_CARRY || op == OP_SUB_BORROW) ? s_q.carryFlag : subOp;
  assign bOperand = useProd ? prodShifted : scaled;
  assign bInv    = subOp ? ~bOperand : bOperand;
  assign sum33   = {1'b0, s_q.accum} + {1'b0, bInv} + {32'h0000_0000, cin};
  assign aluOv   = (s_q.accum[31] == bInv[31]) && (sum33[31] != s_q.accum[31]);
  assign arithRes = (aluOv && s_q.saturateEnable) ?
                    (s_q.accum[31] ? SAT_NEG : SAT_POS) : sum33[31:0];

  // ----------------------------------------
  // Multiplier
  // ----------------------------------------
  always_comb begin
    mulA = s_q.multiplicand;
    mulB = dataReadBus;
    unique case (op)
      OP_MUL_IMM:                      mulB = {{3{immVal[12]}}, immVal};
      OP_SQUARE_ADD, OP_SQUARE_SUB:    mulA = dataReadBus;
      OP_MULT_ACCUM, OP_MULT_ACCUM_MOVE: begin
        mulA = dataReadBus;
        mulB = programReadBus;
      end
      default: ;
    endcase
  end
  assign mulS = $signed(mulA) * $signed(mulB);
  assign mulU = {16'h0000, mulA} * {16'h0000, mulB};

  // ----------------------------------------
  // Status word and handshakes
  // ----------------------------------------
  assign statusWord = {25'h000_0000, s_q.testFlag, s_q.overflowFlag, s_q.carryFlag,
                       s_q.saturateEnable, s_q.signExtEnable, s_q.productShiftSel};
  assign opReady  = !s_q.immPending;
  assign acceptOp = opValid && opReady;
  assign wbHit    = cyc_i && stb_i && !s_q.ack;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = wbHit;
    s_d.storeWr = 1'b0;
    s_d.moveWr = 1'b0;
    s_d.branchTake = 1'b0;
    s_d.immPending = 1'b0;
    if (coefLoad) begin
      s_d.coefAddr = coefStart;
    end
    if (wbHit) begin
      unique case (adr_i)
        ADR_STATUS:  s_d.rdData = statusWord;
        ADR_ACCUM:   s_d.rdData = s_q.accum;
        ADR_PRODUCT: s_d.rdData = s_q.product;
        ADR_MCAND:   s_d.rdData = {16'h0000, s_q.multiplicand};
        default:     s_d.rdData = 32'h0000_0000;
      endcase
      if (we_i && sel_i[0] && adr_i == ADR_STATUS) begin
        s_d.productShiftSel = dat_i[ST_PSEL_HI:ST_PSEL_LO];
        s_d.signExtEnable   = dat_i[ST_SEXT];
        s_d.saturateEnable  = dat_i[ST_SAT];
        s_d.carryFlag       = dat_i[ST_CARRY];
        s_d.overflowFlag    = dat_i[ST_OVF];
        s_d.testFlag        = dat_i[ST_TEST];
      end
    end
    if (acceptOp) begin
      unique case (op)
        OP_NOP: ;
        OP_LOAD_MULT: s_d.multiplicand = dataReadBus;
        OP_LOAD_MULT_PROD: begin
          s_d.multiplicand = dataReadBus;
          s_d.accum = prodShifted;
        end
        OP_LOAD_MULT_ADD, OP_LOAD_MULT_ADD_MOVE, OP_LOAD_MULT_SUB: begin
          s_d.multiplicand = dataReadBus;
          s_d.moveWr = (op == OP_LOAD_MULT_ADD_MOVE);
          s_d.moveData = dataReadBus;
        end
        OP_MUL_SIGNED, OP_MUL_IMM, OP_SQUARE_ADD, OP_SQUARE_SUB: ;
        OP_MUL_UNSIGNED: s_d.product = mulU;
        OP_MULT_ACCUM, OP_MULT_ACCUM_MOVE: begin
          s_d.multiplicand = dataReadBus;
          s_d.coefAddr = s_q.coefAddr + 16'h0001;
          s_d.moveWr = (op == OP_MULT_ACCUM_MOVE);
          s_d.moveData = dataReadBus;
        end
        OP_LOAD, OP_LOAD_VAR: s_d.accum = scaled;
        OP_ADD, OP_ADD_VAR, OP_ADD_CARRY, OP_SUB, OP_SUB_VAR, OP_SUB_BORROW: ;
        OP_AND: s_d.accum = s_q.accum & scaled;
        OP_OR:  s_d.accum = s_q.accum | scaled;
        OP_XOR: s_d.accum = s_q.accum ^ scaled;
        OP_BIT_TEST_VAR: s_d.testFlag = dataReadBus[s_q.multiplicand[3:0]];
        OP_STORE_PROD_HIGH, OP_STORE_PROD_LOW: begin
          s_d.storeWr = 1'b1;
          s_d.storeData = (op == OP_STORE_PROD_HIGH) ?
                          prodShifted[31:16] : prodShifted[15:0];
        end
        OP_LOAD_PROD_HIGH: s_d.product[31:16] = dataReadBus;
        OP_SHIFT_LEFT: begin
          s_d.carryFlag = s_q.accum[31];
          s_d.accum = {s_q.accum[30:0], 1'b0};
        end
        OP_SHIFT_RIGHT: begin
          s_d.carryFlag = s_q.accum[0];
          s_d.accum = {s_q.signExtEnable & s_q.accum[31], s_q.accum[31:1]};
        end
        OP_ROTATE_LEFT: begin
          s_d.carryFlag = s_q.accum[31];
          s_d.accum = {s_q.accum[30:0], s_q.carryFlag};
        end
        OP_ROTATE_RIGHT: begin
          s_d.carryFlag = s_q.accum[0];
          s_d.accum = {s_q.carryFlag, s_q.accum[31:1]};
        end
        OP_BRANCH_OVF: begin
          s_d.branchTake = s_q.overflowFlag;
          s_d.branchAddr = programReadBus;
          s_d.overflowFlag = 1'b0;
        end
        OP_BRANCH_ZERO: begin
          s_d.branchTake = (s_q.accum == 32'h0000_0000);
          s_d.branchAddr = programReadBus;
        end
        OP_JUMP_ACCUM: begin
          s_d.branchTake = 1'b1;
          s_d.branchAddr = s_q.accum[15:0];
        end
        default: ;
      endcase
      // Signed product load, immediate takes a second cycle
      if (op == OP_MUL_SIGNED || op == OP_MUL_IMM || op == OP_SQUARE_ADD ||
          op == OP_SQUARE_SUB || op == OP_MULT_ACCUM || op == OP_MULT_ACCUM_MOVE) begin
        s_d.product = mulS;
        s_d.immPending = (op == OP_MUL_IMM);
      end
      // Arithmetic write-back, carry and overflow
      if (useProd || op == OP_ADD || op == OP_ADD_VAR || op == OP_ADD_CARRY ||
          op == OP_SUB || op == OP_SUB_VAR || op == OP_SUB_BORROW) begin
        s_d.accum = arithRes;
        if (!varOp && shiftCnt == SHIFT_HIGH && op == OP_ADD) begin
          s_d.carryFlag = s_q.carryFlag | sum33[32];
        end else if (!varOp && shiftCnt == SHIFT_HIGH && op == OP_SUB) begin
          s_d.carryFlag = s_q.carryFlag & sum33[32];
        end else begin
          s_d.carryFlag = sum33[32];
        end
        if (aluOv) begin
          s_d.overflowFlag = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.productShiftSel <= PSEL_NONE;
      s_q.signExtEnable <= SEXT_RST;
      s_q.saturateEnable <= SAT_RST;
      s_q.carryFlag <= CARRY_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign coefAddr     = s_q.coefAddr;
  assign accum        = s_q.accum;
  assign carryFlag    = s_q.carryFlag;
  assign overflowFlag = s_q.overflowFlag;
  assign testFlag     = s_q.testFlag;
  assign storeWr      = s_q.storeWr;
  assign storeData    = s_q.storeData;
  assign moveWr       = s_q.moveWr;
  assign moveData     = s_q.moveData;
  assign branchTake   = s_q.branchTake;
  assign branchAddr   = s_q.branchAddr;
  assign dat_o        = s_q.rdData;
  assign ack_o        = s_q.ack;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic acc1;
  assign acc1 = acceptOp && ce;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_prod_l1;
    acc1 && op == OP_LOAD_MULT_PROD && s_q.productShiftSel == PSEL_L1
      |=> accum == {$past(s_q.product[30:0]), 1'b0};
  endproperty
  a_prod_l1: assert property (p_prod_l1) else $error("left one shift wrong");

  property p_prod_r6;
    acc1 && op == OP_LOAD_MULT_PROD && s_q.productShiftSel == PSEL_R6
      |=> accum == {{6{$past(s_q.product[31])}}, $past(s_q.product[31:6])};
  endproperty
  a_prod_r6: assert property (p_prod_r6) else $error("right six shift wrong");

  property p_sat_pos;
    acc1 && op == OP_ADD && s_q.saturateEnable && aluOv && !s_q.accum[31]
      |=> accum == SAT_POS && overflowFlag;
  endproperty
  a_sat_pos: assert property (p_sat_pos) else $error("positive clamp missing");

  property p_load_keeps_carry;
    acc1 && (op == OP_LOAD || op == OP_AND) |=> carryFlag == $past(carryFlag);
  endproperty
  a_load_keeps_carry: assert property (p_load_keeps_carry) else $error("carry changed");

  property p_ovf_sticky;
    overflowFlag && !(acc1 && op == OP_BRANCH_OVF) && !(wbHit && we_i && ce)
      |=> overflowFlag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

  property p_bit_test;
    acc1 && op == OP_BIT_TEST_VAR
      |=> accum == $past(accum) && testFlag == $past(dataReadBus[s_q.multiplicand[3:0]]);
  endproperty
  a_bit_test: assert property (p_bit_test) else $error("bit test wrong");

  sequence s_imm_issue;
    acc1 && op == OP_MUL_IMM;
  endsequence
  sequence s_imm_gap;
    !opReady ##1 opReady;
  endsequence
  property p_imm_two_cycles;
    s_imm_issue |=> s_imm_gap;
  endproperty
  a_imm_two_cycles: assert property (p_imm_two_cycles) else $error("immediate rate wrong");

  property p_move;
    acc1 && op == OP_MULT_ACCUM_MOVE
      |=> moveWr && moveData == $past(dataReadBus) && coefAddr == $past(coefAddr) + 16'h0001;
  endproperty
  a_move: assert property (p_move) else $error("sample move wrong");

  property p_add_high;
    acc1 && op == OP_ADD && shiftCnt == SHIFT_HIGH && carryFlag |=> carryFlag;
  endproperty
  a_add_high: assert property (p_add_high) else $error("high add cleared carry");

endmodule

// file: bench/mad_coef_rom.sv
/*
  Coefficient table model on the program read bus.
  Assumes the datapath supplies the coefficient address.
*/
`timescale 1ns/1ps
module mad_coef_rom (
  // Address in
  input  wire logic [15:0] coefAddr,
  // Coefficient out
  output      logic [15:0] coefData
);
  // Table content derived from the address
  assign coefData = coefAddr ^ 16'hA5C3;
endmodule

// file: bench/tb.sv
/*
  Testbench of the multiplier and ALU datapath.
  Assumes the design answers Wishbone in one cycle and ops as noted.
*/
`timescale 1ns/1ps
module tb
  import mad_pkg::*;
;
  logic mclk, rst, opValid, opReady, coefLoad, carryFlag, overflowFlag, testFlag;
  logic storeWr, moveWr, branchTake, cyc, stb, we, ack;
  mad_op_t opCode;
  logic [4:0] shiftCnt;
  logic [12:0] immVal;
  logic [15:0] dataBus, progBus, coefStart, coefAddr, storeData, moveData, branchAddr;
  logic [31:0] accum, wdat, rdat, p, e;
  logic [3:0] adr;
  int bad_count, total_checks;

  // ----------------------------------------
  // Clock, design and partner
  // ----------------------------------------
  always #20 mclk = ~mclk;

  mad_datapath mad_datapath_i (.mclk(mclk), .rst(rst), .ce(1'b1), .opValid(opValid), .opReady(opReady),
    .op(opCode), .shiftCnt(shiftCnt), .immVal(immVal), .dataReadBus(dataBus), .programReadBus(progBus),
    .coefLoad(coefLoad), .coefStart(coefStart), .coefAddr(coefAddr), .accum(accum), .carryFlag(carryFlag),
    .overflowFlag(overflowFlag), .testFlag(testFlag), .storeWr(storeWr), .storeData(storeData),
    .moveWr(moveWr), .moveData(moveData), .branchTake(branchTake), .branchAddr(branchAddr), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack));

  mad_coef_rom mad_coef_rom_i (.coefAddr(coefAddr), .coefData(progBus));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] smul(input logic [15:0] a, input logic [15:0] b);
    return {{16{a[15]}}, a} * {{16{b[15]}}, b};
  endfunction

  function automatic logic [31:0] pshift(input logic [31:0] v, input logic [1:0] m);
    case (m)
      PSEL_NONE: return v;
      PSEL_L1: return v << 1;
      PSEL_L4: return v << 4;
      default: return {{6{v[31]}}, v[31:6]};
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(negedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
    end
    @(posedge mclk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q, x);
  endtask

  task automatic doOp(input mad_op_t o, input logic [15:0] d, input logic [4:0] s = 5'h00,
                      input logic [12:0] i = 13'h0000);
    @(posedge mclk);
    opValid <= 1'b1;
    opCode <= o;
    dataBus <= d;
    shiftCnt <= s;
    immVal <= i;
    @(posedge mclk);
    opValid <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    complete_run;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    {opValid, coefLoad, cyc, stb, we} = 5'h00;
    opCode = OP_NOP;
    {shiftCnt, immVal, dataBus, coefStart, adr, wdat} = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(ADR_STATUS, 32'h0000_0014);
    rd(4'h2, 32'h0000_0000);
    // Product shifter modes
    doOp(OP_LOAD_MULT, 16'hC003);
    doOp(OP_MUL_SIGNED, 16'h0123);
    p = smul(16'hC003, 16'h0123);
    rd(ADR_PRODUCT, p);
    for (int m = 0; m < 4; m++) begin
      wr(ADR_STATUS, 32'h0000_0014 | 32'(m));
      doOp(OP_LOAD_MULT_PROD, 16'h0005);
      chk(accum, pshift(p, 2'(m)));
    end
    e = pshift(p, PSEL_R6);
    doOp(OP_STORE_PROD_HIGH, 16'h0000);
    chk(storeWr, 1'b1);
    chk(storeData, e[31:16]);
    rd(ADR_PRODUCT, p);
    // Multiplies
    wr(ADR_STATUS, 32'h0000_0014);
    doOp(OP_LOAD_MULT, 16'hFFFF);
    doOp(OP_MUL_UNSIGNED, 16'hFFFF);
    rd(ADR_PRODUCT, 32'hFFFE_0001);
    doOp(OP_MUL_SIGNED, 16'hFFFF);
    rd(ADR_PRODUCT, 32'h0000_0001);
    doOp(OP_MUL_IMM, 16'h0000, 5'h00, 13'h1FFD);
    chk(opReady, 1'b0);
    @(negedge mclk);
    chk(opReady, 1'b1);
    rd(ADR_PRODUCT, 32'h0000_0003);
    doOp(OP_MUL_IMM, 16'h0000);
    rd(ADR_PRODUCT, 32'h0000_0000);
    doOp(OP_LOAD_MULT, 16'h5678);
    doOp(OP_MUL_IMM, 16'h0000, 5'h00, 13'h0001);
    doOp(OP_LOAD_PROD_HIGH, 16'h1234);
    rd(ADR_PRODUCT, 32'h1234_5678);
    doOp(OP_SQUARE_ADD, 16'hFFFD);
    rd(ADR_PRODUCT, 32'h0000_0009);
    // Input shifter and saturation
    wr(ADR_STATUS, 32'h0000_0010);
    doOp(OP_LOAD, 16'h8000, 5'h04);
    chk(accum, 32'h0008_0000);
    wr(ADR_STATUS, 32'h0000_001C);
    doOp(OP_LOAD, 16'h8000, 5'h04);
    chk(accum, 32'hFFF8_0000);
    doOp(OP_LOAD, 16'h8000, 5'h10);
    doOp(OP_SUB, 16'h0001, 5'h10);
    chk(accum, SAT_NEG);
    doOp(OP_LOAD, 16'h7FFF, 5'h10);
    doOp(OP_ADD, 16'h7FFF, 5'h10);
    chk(accum, SAT_POS);
    chk(overflowFlag, 1'b1);
    doOp(OP_BRANCH_OVF, 16'h0000);
    chk(overflowFlag, 1'b0);
    chk(branchTake, 1'b1);
    chk(branchAddr, 16'hA5C3);
    wr(ADR_STATUS, 32'h0000_0014);
    doOp(OP_LOAD, 16'h7FFF, 5'h10);
    doOp(OP_ADD, 16'h7FFF, 5'h10);
    chk(accum, 32'hFFFE_0000);
    chk(overflowFlag, 1'b1);
    wr(ADR_ACCUM, 32'h0000_0000);
    rd(ADR_ACCUM, 32'hFFFE_0000);
    // Carry handling
    wr(ADR_STATUS, 32'h0000_0004);
    doOp(OP_LOAD, 16'hFFFF);
    doOp(OP_ADD, 16'h0001);
    chk(accum, 32'h0000_0000);
    chk(carryFlag, 1'b1);
    doOp(OP_OR, 16'h0000);
    chk(carryFlag, 1'b1);
    doOp(OP_ADD, 16'h0001, 5'h10);
    chk(carryFlag, 1'b1);
    doOp(OP_ADD_CARRY, 16'h0000);
    chk(accum, 32'h0001_0001);
    chk(carryFlag, 1'b0);
    doOp(OP_SUB, 16'h0002);
    chk(accum, 32'h0000_FFFF);
    chk(carryFlag, 1'b1);
    // Variable shift and bit test
    doOp(OP_LOAD_MULT, 16'h0005);
    doOp(OP_BIT_TEST_VAR, 16'h0020);
    chk(testFlag, 1'b1);
    chk(accum, 32'h0000_FFFF);
    doOp(OP_BIT_TEST_VAR, 16'hFFDF);
    chk(testFlag, 1'b0);
    doOp(OP_LOAD_VAR, 16'h0003);
    chk(accum, 32'h0000_0060);
    // Multiply-accumulate
    @(posedge mclk);
    coefLoad <= 1'b1;
    coefStart <= 16'h0010;
    @(posedge mclk);
    coefLoad <= 1'b0;
    doOp(OP_MULT_ACCUM, 16'h0002);
    chk(coefAddr, 16'h0011);
    chk(accum, 32'h0000_0069);
    rd(ADR_PRODUCT, smul(16'h0002, 16'hA5D3));
    e = 32'h0000_0069 + smul(16'h0002, 16'hA5D3);
    doOp(OP_MULT_ACCUM_MOVE, 16'h0007);
    chk(accum, e);
    chk(moveWr, 1'b1);
    chk(moveData, 16'h0007);
    doOp(OP_JUMP_ACCUM, 16'h0000);
    chk(branchTake, 1'b1);
    chk(branchAddr, e[15:0]);
    complete_run;
  end
endmodule
